//--- latency_sync_pkg.sv
// Shared constants, phase table and helper functions for the latency alignment link
package latency_sync_pkg;
  // Link and data widths
  localparam int DATA_W = 16;
  localparam int CFG_AW = 7;
  localparam int CFG_DW = 8;
  // Converter register map
  localparam logic [6:0] SYNC_CTRL_ADDR = 7'h05;
  localparam logic [6:0] PHASE_READOUT_ADDR = 7'h06;
  localparam logic [7:0] SYNC_CTRL_RESET = 8'h00;
  localparam logic [7:0] PHASE_READOUT_RESET = 8'h00;
  localparam int PS_LSB = 0;
  localparam int MANUAL_BIT = 2;
  // Phase comparator geometry: four sample cycles per data clock, five delay bins per cycle
  localparam int PHASE_GROUPS = 4;
  localparam int DELAY_BINS = 5;
  localparam int BIN_TENTHS = 2;
  localparam int LATE_BIN_MIN = 3;
  localparam int MISMATCH_LIMIT_TENTHS = 4;
  localparam logic [1:0] LOAD_OFFSET = 2'h2;
  localparam logic [7:0] PHASE_CODE [PHASE_GROUPS*DELAY_BINS] = '{
    8'h03, 8'h04, 8'h05, 8'h15, 8'h25,
    8'h35, 8'h45, 8'h55, 8'h54, 8'h53,
    8'h52, 8'h51, 8'h50, 8'h40, 8'h30,
    8'h20, 8'h10, 8'h00, 8'h01, 8'h02};
  localparam logic [1:0] PS_DEFAULT [PHASE_GROUPS] = '{2'h2, 2'h0, 2'h1, 2'h3};
  // Timing counts in hclk cycles
  localparam int SAMPLE_SUBSTEPS = 5;
  localparam int DCLK_HALF = 10;
  localparam int MONITOR_INTERVAL = 1000;
  // Host register map on the AHB-Lite side
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_REF_OFS = 8'h04;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h08;
  localparam logic [7:0] HOST_DIRECT_OFS = 8'h0c;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_MON_BIT = 1;

  // Readout code of a phase group and delay bin
  function automatic logic [7:0] phase_code(input logic [1:0] grp, input logic [2:0] bin);
    phase_code = PHASE_CODE[int'(grp) * DELAY_BINS + int'(bin)];
  endfunction

  // Reverse lookup: {found, group, bin}
  function automatic logic [5:0] phase_decode(input logic [7:0] code);
    phase_decode = 6'h00;
    for (int i = 0; i < PHASE_GROUPS*DELAY_BINS; i++)
    begin
      if (PHASE_CODE[i] == code)
      begin
        phase_decode = {1'b1, 2'(i / DELAY_BINS), 3'(i % DELAY_BINS)};
      end
    end
  endfunction

  // Phase group whose default selection equals ps
  function automatic logic [1:0] ps_slot(input logic [1:0] ps);
    ps_slot = 2'h0;
    for (int i = 0; i < PHASE_GROUPS; i++)
    begin
      if (PS_DEFAULT[i] == ps)
      begin
        ps_slot = 2'(i);
      end
    end
  endfunction
endpackage

//--- sync_link_if.sv
// Link between the converter synchronizer and its host: data clock, data ports, config port
`timescale 1ns/1ps
interface sync_link_if #(parameter int DW = 16);
  logic data_clock_input;
  logic [DW-1:0] first_data_port;
  logic [DW-1:0] second_data_port;
  logic cfg_req;
  logic cfg_we;
  logic [6:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic cfg_ack;
  logic [7:0] cfg_rdata;

  modport dev (
    input data_clock_input, first_data_port, second_data_port,
    input cfg_req, cfg_we, cfg_addr, cfg_wdata,
    output cfg_ack, cfg_rdata
  );

  modport host (
    output data_clock_input, first_data_port, second_data_port,
    output cfg_req, cfg_we, cfg_addr, cfg_wdata,
    input cfg_ack, cfg_rdata
  );
endinterface

//--- dac_sync_device.sv
// Converter end: data clock synchronizer, phase comparator, latency select and config registers
`timescale 1ns/1ps
module dac_sync_device
  import latency_sync_pkg::*;
#(
  parameter int SUBSTEPS = SAMPLE_SUBSTEPS,
  parameter int DW = DATA_W
)
(
  input wire logic hclk,
  input wire logic hresetn,
  sync_link_if.dev link,
  output logic [DW-1:0] sample_a_out,
  output logic [DW-1:0] sample_b_out,
  output logic sample_update,
  output logic [1:0] active_phase_select
);
  localparam int FW = (SUBSTEPS > 1) ? $clog2(SUBSTEPS) : 1;
  localparam logic [FW-1:0] FINE_LAST = FW'(SUBSTEPS - 1);

  // Two-stage synchronisers for the data clock and data ports
  logic dck_meta_q, dck_sync_q, dck_prev_q;
  logic [DW-1:0] a_meta_q, a_sync_q, b_meta_q, b_sync_q;
  logic dck_meta_d, dck_sync_d, dck_prev_d;
  logic [DW-1:0] a_meta_d, a_sync_d, b_meta_d, b_sync_d;

  // Sample clock timebase: fine steps inside a sample cycle, sample cycle within data clock
  logic [FW-1:0] fine_q, fine_d;
  logic [1:0] phase_q, phase_d;

  // Phase comparator and latency state
  logic [7:0] readout_q, readout_d;
  logic [1:0] auto_ps_q, auto_ps_d;
  logic [DW-1:0] hold_a_q, hold_a_d, hold_b_q, hold_b_d;
  logic pending_q, pending_d;
  logic [DW-1:0] out_a_q, out_a_d, out_b_q, out_b_d;
  logic update_q, update_d;

  // Configuration registers and port answer
  logic [7:0] ctrl_q, ctrl_d;
  logic ack_q, ack_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] eff_ps_q, eff_ps_d;

  logic dck_rise;
  logic strobe;
  logic [2:0] edge_bin;
  logic [1:0] eff_ps;
  logic [1:0] load_phase;
  logic load;

  // Synchroniser chain; the second stage and the delayed third stage feed the edge detector
  always_comb
  begin
    dck_meta_d = link.data_clock_input;
    dck_sync_d = dck_meta_q;
    dck_prev_d = dck_sync_q;
    a_meta_d = link.first_data_port;
    a_sync_d = a_meta_q;
    b_meta_d = link.second_data_port;
    b_sync_d = b_meta_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dck_meta_q <= 1'b0;
      dck_sync_q <= 1'b0;
      dck_prev_q <= 1'b0;
      a_meta_q <= '0;
      a_sync_q <= '0;
      b_meta_q <= '0;
      b_sync_q <= '0;
    end
    else
    begin
      dck_meta_q <= dck_meta_d;
      dck_sync_q <= dck_sync_d;
      dck_prev_q <= dck_prev_d;
      a_meta_q <= a_meta_d;
      a_sync_q <= a_sync_d;
      b_meta_q <= b_meta_d;
      b_sync_q <= b_sync_d;
    end
  end

  assign dck_rise = dck_sync_q & ~dck_prev_q;
  assign strobe = (fine_q == FINE_LAST);
  // Distance left to the next sample edge, scaled to the five delay bins
  assign edge_bin = 3'(((SUBSTEPS - 1 - int'(fine_q)) * DELAY_BINS) / SUBSTEPS);
  // Manual mode replaces the automatic choice with the written field
  assign eff_ps = ctrl_q[MANUAL_BIT] ? ctrl_q[PS_LSB+1:PS_LSB] : auto_ps_q;
  // Output loads a fixed number of sample cycles after the selected slot
  assign load_phase = ps_slot(eff_ps) + LOAD_OFFSET;
  assign load = strobe & pending_q & (phase_q == load_phase);

  // Free-running sample timebase; it never stops, so the measured phase stays meaningful
  always_comb
  begin
    fine_d = strobe ? '0 : fine_q + FW'(1);
    phase_d = strobe ? phase_q + 2'h1 : phase_q;
  end

  // Comparator: latch code and automatic select on each rising data clock edge
  always_comb
  begin
    readout_d = readout_q;
    auto_ps_d = auto_ps_q;
    if (dck_rise)
    begin
      readout_d = phase_code(phase_q, edge_bin);
      auto_ps_d = PS_DEFAULT[phase_q];
    end
  end

  // Capture at the data clock edge, present at the selected sample edge
  always_comb
  begin
    hold_a_d = hold_a_q;
    hold_b_d = hold_b_q;
    pending_d = pending_q;
    out_a_d = out_a_q;
    out_b_d = out_b_q;
    update_d = 1'b0;
    if (load)
    begin
      out_a_d = hold_a_q;
      out_b_d = hold_b_q;
      update_d = 1'b1;
      pending_d = 1'b0;
    end
    // A new capture in the load cycle keeps the word pending
    if (dck_rise)
    begin
      hold_a_d = a_sync_q;
      hold_b_d = b_sync_q;
      pending_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fine_q <= '0;
      phase_q <= 2'h0;
      readout_q <= PHASE_READOUT_RESET;
      auto_ps_q <= PS_DEFAULT[0];
      hold_a_q <= '0;
      hold_b_q <= '0;
      pending_q <= 1'b0;
      out_a_q <= '0;
      out_b_q <= '0;
      update_q <= 1'b0;
    end
    else
    begin
      fine_q <= fine_d;
      phase_q <= phase_d;
      readout_q <= readout_d;
      auto_ps_q <= auto_ps_d;
      hold_a_q <= hold_a_d;
      hold_b_q <= hold_b_d;
      pending_q <= pending_d;
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
      update_q <= update_d;
    end
  end

  // Config port: one request per pulse, answered on the next edge
  always_comb
  begin
    ctrl_d = ctrl_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    eff_ps_d = eff_ps;
    if (link.cfg_req)
    begin
      ack_d = 1'b1;
      rdata_d = 8'h00;
      if (link.cfg_we)
      begin
        if (link.cfg_addr == SYNC_CTRL_ADDR)
        begin
          ctrl_d = link.cfg_wdata;
        end
      end
      else if (link.cfg_addr == SYNC_CTRL_ADDR)
      begin
        rdata_d = ctrl_q;
      end
      else if (link.cfg_addr == PHASE_READOUT_ADDR)
      begin
        rdata_d = readout_q;
      end
    end
  end

  // Control word holds until rewritten; only reset clears it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= SYNC_CTRL_RESET;
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      eff_ps_q <= PS_DEFAULT[0];
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      eff_ps_q <= eff_ps_d;
    end
  end

  assign link.cfg_ack = ack_q;
  assign link.cfg_rdata = rdata_q;
  assign sample_a_out = out_a_q;
  assign sample_b_out = out_b_q;
  assign sample_update = update_q;
  assign active_phase_select = eff_ps_q;
endmodule

//--- dac_sync_host.sv
// Host end: data clock divider, sample feed, AHB-Lite registers and the alignment sequencer
`timescale 1ns/1ps
module dac_sync_host
  import latency_sync_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int HALF = DCLK_HALF,
  parameter int MON_CYCLES = MONITOR_INTERVAL
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [DW-1:0] sample_a_in,
  input wire logic [DW-1:0] sample_b_in,
  output logic sample_taken,
  sync_link_if.host link
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_READ = 5'b00010, S_DECIDE = 5'b00100, S_WRITE = 5'b01000, S_WAIT = 5'b10000
  } host_state_t;

  // Divider and sample feed; data changes on the falling data clock so the rise sees it settled
  logic [15:0] div_q, div_d;
  logic dck_q, dck_d;
  logic [DW-1:0] pa_q, pa_d, pb_q, pb_d;
  logic taken_q, taken_d;
  logic div_end;
  assign div_end = (div_q == 16'(HALF - 1));

  always_comb
  begin
    div_d = div_end ? 16'h0000 : div_q + 16'h0001;
    dck_d = div_end ? ~dck_q : dck_q;
    pa_d = pa_q;
    pb_d = pb_q;
    taken_d = 1'b0;
    if (div_end && dck_q)
    begin
      pa_d = sample_a_in;
      pb_d = sample_b_in;
      taken_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q <= 16'h0000;
      dck_q <= 1'b0;
      pa_q <= '0;
      pb_q <= '0;
      taken_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      dck_q <= dck_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
      taken_q <= taken_d;
    end
  end

  // AHB-Lite slave, zero wait states; writes land in the data phase
  logic wr_q, wr_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] rd_q, rd_d;
  logic mon_q, mon_d, go_q, go_d, direct_q, direct_d;
  logic [4:0] ref_q, ref_d;
  logic [7:0] direct_val_q, direct_val_d;
  logic [7:0] code_q, code_d;
  logic [1:0] ps_q, ps_d;
  logic late_q, late_d;
  host_state_t st_q, st_d;
  logic req_q, req_d, we_q, we_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] wd_q, wd_d;
  logic [15:0] mon_cnt_q, mon_cnt_d;
  logic [5:0] dec;
  logic [5:0] delay_t;
  logic is_late;
  logic addr_phase;
  logic start;

  assign addr_phase = hsel & htrans[1] & hready;
  assign dec = phase_decode(code_q);
  assign delay_t = 6'(int'(dec[2:0]) * BIN_TENTHS + 1);
  // Late: decoded delay beyond the reference by more than 0.4 cycles, in a correctable bin
  assign is_late = dec[5] && (dec[2:0] >= 3'(LATE_BIN_MIN))
    && (delay_t > 6'(int'(ref_q) + MISMATCH_LIMIT_TENTHS));
  assign start = (st_q == S_IDLE) && (go_q || direct_q);

  always_comb
  begin
    wr_d = addr_phase & hwrite;
    waddr_d = addr_phase ? haddr[7:0] : waddr_q;
    rd_d = rd_q;
    mon_d = mon_q;
    ref_d = ref_q;
    direct_val_d = direct_val_q;
    // Sequencer start clears the request, a new write in the same cycle wins
    go_d = go_q & ~(start & ~direct_q);
    direct_d = direct_q & ~start;
    if (addr_phase && !hwrite)
    begin
      unique case (haddr[7:0])
        HOST_CTRL_OFS: rd_d = {30'h0, mon_q, 1'b0};
        HOST_REF_OFS: rd_d = {27'h0, ref_q};
        HOST_STATUS_OFS: rd_d = {14'h0, ps_q, code_q, 5'h0, late_q, dec[5], st_q != S_IDLE};
        default: rd_d = 32'h0;
      endcase
    end
    if (wr_q)
    begin
      if (waddr_q == HOST_CTRL_OFS)
      begin
        mon_d = hwdata[CTRL_MON_BIT];
        go_d = go_d | hwdata[CTRL_GO_BIT];
      end
      if (waddr_q == HOST_REF_OFS)
      begin
        ref_d = hwdata[4:0];
      end
      if (waddr_q == HOST_DIRECT_OFS)
      begin
        direct_val_d = hwdata[7:0];
        direct_d = 1'b1;
      end
    end
  end

  // Sequencer: read readout, decide, write correction, optionally keep watching
  always_comb
  begin
    st_d = st_q;
    req_d = 1'b0;
    we_d = we_q;
    addr_d = addr_q;
    wd_d = wd_q;
    code_d = code_q;
    ps_d = ps_q;
    late_d = late_q;
    mon_cnt_d = mon_cnt_q;
    unique case (st_q)
      S_IDLE:
      begin
        if (direct_q)
        begin
          {req_d, we_d, addr_d, wd_d} = {2'h3, SYNC_CTRL_ADDR, direct_val_q};
          ps_d = direct_val_q[PS_LSB+1:PS_LSB];
          st_d = S_WRITE;
        end
        else if (go_q)
        begin
          {req_d, we_d, addr_d} = {2'h2, PHASE_READOUT_ADDR};
          st_d = S_READ;
        end
      end
      S_READ:
      begin
        if (link.cfg_ack)
        begin
          code_d = link.cfg_rdata;
          st_d = S_DECIDE;
        end
      end
      S_DECIDE:
      begin
        late_d = is_late;
        if (is_late)
        begin
          // Adopt the next group's default, e.g. readout 0x25 moves 10 to 00
          ps_d = PS_DEFAULT[dec[4:3] + 2'h1];
          wd_d = 8'h00;
          wd_d[MANUAL_BIT] = 1'b1;
          wd_d[PS_LSB+1:PS_LSB] = PS_DEFAULT[dec[4:3] + 2'h1];
          {req_d, we_d, addr_d} = {2'h3, SYNC_CTRL_ADDR};
          st_d = S_WRITE;
        end
        else
        begin
          st_d = mon_q ? S_WAIT : S_IDLE;
        end
        mon_cnt_d = 16'h0000;
      end
      S_WRITE:
      begin
        if (link.cfg_ack)
        begin
          st_d = mon_q ? S_WAIT : S_IDLE;
        end
        mon_cnt_d = 16'h0000;
      end
      S_WAIT:
      begin
        // Drift can move the phase, so the readout is polled again
        mon_cnt_d = mon_cnt_q + 16'h0001;
        if (!mon_q || direct_q)
        begin
          st_d = S_IDLE;
        end
        else if (mon_cnt_q == 16'(MON_CYCLES - 1))
        begin
          {req_d, we_d, addr_d} = {2'h2, PHASE_READOUT_ADDR};
          st_d = S_READ;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {wr_q, waddr_q, rd_q, mon_q, go_q, direct_q, ref_q, direct_val_q} <= '0;
      {code_q, ps_q, late_q, req_q, we_q, addr_q, wd_q, mon_cnt_q} <= '0;
      st_q <= S_IDLE;
    end
    else
    begin
      {wr_q, waddr_q, rd_q, mon_q, go_q, direct_q, ref_q, direct_val_q} <=
        {wr_d, waddr_d, rd_d, mon_d, go_d, direct_d, ref_d, direct_val_d};
      {code_q, ps_q, late_q, req_q, we_q, addr_q, wd_q, mon_cnt_q} <=
        {code_d, ps_d, late_d, req_d, we_d, addr_d, wd_d, mon_cnt_d};
      st_q <= st_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_q;
  assign sample_taken = taken_q;
  assign link.data_clock_input = dck_q;
  assign link.first_data_port = pa_q;
  assign link.second_data_port = pb_q;
  assign link.cfg_req = req_q;
  assign link.cfg_we = we_q;
  assign link.cfg_addr = addr_q;
  assign link.cfg_wdata = wd_q;
endmodule

//--- multi_dac_latency_sync_assertions.sv
// Concurrent checks on the link between the host end and the converter end
`timescale 1ns/1ps
module multi_dac_latency_sync_assertions
  import latency_sync_pkg::*;
#(
  parameter int HALF = DCLK_HALF
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic data_clock_input,
  input wire logic [15:0] first_data_port,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [6:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [7:0] cfg_rdata
);
  logic known_code;
  logic dck_q;
  logic dck_d;
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic seen_q;
  logic seen_d;

  // Readout must be one of the twenty comparator codes
  always_comb
  begin
    known_code = 1'b0;
    for (int i = 0; i < PHASE_GROUPS*DELAY_BINS; i++)
    begin
      if (PHASE_CODE[i] == cfg_rdata)
      begin
        known_code = 1'b1;
      end
    end
  end

  // Cycles since the last data clock toggle; seen guards the first half period
  always_comb
  begin
    dck_d = data_clock_input;
    run_d = (data_clock_input != dck_q) ? 8'h00 : run_q + 8'h01;
    seen_d = seen_q | (data_clock_input != dck_q);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dck_q <= 1'b0;
      run_q <= 8'h00;
      seen_q <= 1'b0;
    end
    else
    begin
      dck_q <= dck_d;
      run_q <= run_d;
      seen_q <= seen_d;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ack_after_req_a: assert property (cfg_req |=> cfg_ack)
    else $error("config ack missing one cycle after request");
  ack_single_a: assert property (cfg_ack |=> !cfg_ack)
    else $error("config ack longer than one cycle");
  ack_caused_a: assert property (cfg_ack |-> $past(cfg_req))
    else $error("config ack without request");
  req_spacing_a: assert property (cfg_req |=> !cfg_req)
    else $error("second config request before ack");
  rdata_hold_a: assert property (!cfg_ack |-> $stable(cfg_rdata))
    else $error("config read data moved outside ack");
  write_target_a: assert property (cfg_req && cfg_we |-> cfg_addr == SYNC_CTRL_ADDR)
    else $error("config write not aimed at sync control");
  read_target_a: assert property (cfg_req && !cfg_we |-> cfg_addr == PHASE_READOUT_ADDR)
    else $error("config read not aimed at phase readout");
  readout_code_a: assert property (cfg_req && !cfg_we |=> known_code)
    else $error("phase readout outside code table");
  dclk_half_a: assert property (seen_q && data_clock_input != dck_q |-> run_q == 8'(HALF - 1))
    else $error("data clock half period wrong");
  port_setup_a: assert property ($changed(first_data_port) |-> !data_clock_input)
    else $error("data port changed while data clock high");

  // Main scenarios reached
  cover property (cfg_req && cfg_we && cfg_wdata == 8'h04);
  cover property (cfg_req && !cfg_we ##1 cfg_ack);
  cover property ($rose(data_clock_input));
endmodule

//--- multi_dac_latency_sync_bench.sv
// Self-checking bench: host and converter ends joined by their link, driven over AHB-Lite
`timescale 1ns/1ps
module multi_dac_latency_sync_bench
  import latency_sync_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn;
  logic dev_resetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [15:0] sample_a_in;
  logic [15:0] sample_b_in;
  logic sample_taken;
  logic [15:0] sample_a_out;
  logic [15:0] sample_b_out;
  logic sample_update;
  logic [1:0] active_phase_select;
  logic [31:0] rd;
  logic [7:0] last_wbyte;
  logic [15:0] last_port = 16'h0;
  int n_mismatch = 0;
  int compares = 0;
  int n_reads = 0;
  int idx;
  int snap;

  sync_link_if #(.DW(16)) sync_link_if_inst ();

  dac_sync_host #(.MON_CYCLES(20)) dac_sync_host_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sample_a_in(sample_a_in), .sample_b_in(sample_b_in),
    .sample_taken(sample_taken), .link(sync_link_if_inst)
  );

  dac_sync_device dac_sync_device_inst (
    .hclk(hclk), .hresetn(dev_resetn), .link(sync_link_if_inst), .sample_a_out(sample_a_out),
    .sample_b_out(sample_b_out), .sample_update(sample_update),
    .active_phase_select(active_phase_select)
  );

  multi_dac_latency_sync_assertions #(.HALF(DCLK_HALF)) multi_dac_latency_sync_assertions_inst (
    .hclk(hclk), .hresetn(hresetn), .data_clock_input(sync_link_if_inst.data_clock_input),
    .first_data_port(sync_link_if_inst.first_data_port), .cfg_req(sync_link_if_inst.cfg_req),
    .cfg_we(sync_link_if_inst.cfg_we), .cfg_addr(sync_link_if_inst.cfg_addr),
    .cfg_wdata(sync_link_if_inst.cfg_wdata), .cfg_ack(sync_link_if_inst.cfg_ack),
    .cfg_rdata(sync_link_if_inst.cfg_rdata)
  );

  always #2 hclk = ~hclk;

  // Watch the link: count readout fetches, keep the last byte written
  always @(posedge hclk)
  begin
    if (sync_link_if_inst.cfg_req === 1'b1 && sync_link_if_inst.cfg_we === 1'b0)
      n_reads++;
    if (sync_link_if_inst.cfg_req === 1'b1 && sync_link_if_inst.cfg_we === 1'b1)
      last_wbyte = sync_link_if_inst.cfg_wdata;
    // A new word on the link must come with the taken pulse of the same edge
    if (sync_link_if_inst.first_data_port !== last_port)
    begin
      chk("taken with port", 32'h1, {31'h0, sample_taken});
      last_port = sync_link_if_inst.first_data_port;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single AHB-Lite transfer; waits on hready, no assumed latency
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp okay", 32'h0, {31'h0, hresp});
  endtask

  // Set the reference, start one alignment pass and poll until it is done
  task automatic run_align(input logic [31:0] ref_tenths);
    ahb(1'b1, HOST_REF_OFS, ref_tenths, rd);
    ahb(1'b1, HOST_CTRL_OFS, 32'h1, rd);
    rd = 32'h1;
    for (int k = 0; k < 50 && rd[0] !== 1'b0; k++)
      ahb(1'b0, HOST_STATUS_OFS, 32'h0, rd);
    idx = -1;
    for (int i = 0; i < PHASE_GROUPS*DELAY_BINS; i++)
      if (PHASE_CODE[i] === rd[15:8])
        idx = i;
    chk("readout in table", 32'h1, {31'h0, idx >= 0});
    if (idx < 0)
      idx = 0;
  endtask

  task automatic print_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, well beyond the roughly one thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    hresetn = 1'b0;
    dev_resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sample_a_in = 16'h0;
    sample_b_in = 16'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // Converter leaves reset twelve cycles later, so its data edges land in the first step of a group-0 sample cycle
    repeat (12) @(posedge hclk);
    dev_resetn <= 1'b1;
    // Reset values and an unmapped word
    ahb(1'b0, HOST_CTRL_OFS, 32'h0, rd);
    chk("ctrl reset", 32'h0, rd);
    ahb(1'b0, HOST_STATUS_OFS, 32'h0, rd);
    // Code 0x00 is itself a table entry, so the decoded flag is set from reset
    chk("status reset", 32'h2, rd);
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    // Comparator needs a few data clock periods to settle
    repeat (200) @(posedge hclk);
    run_align(32'h1f);
    // Edge one step after a sample edge in group 0: the 0.8 to 1.0 cycle code
    chk("readout phase", 32'h25, {24'h0, rd[15:8]});
    chk("no late at high reference", 32'h0, {30'h0, rd[2:1]} ^ 32'h1);
    chk("auto select", {30'h0, PS_DEFAULT[idx / DELAY_BINS]}, {30'h0, active_phase_select});
    // Every manual select, written straight through
    for (int ps = 0; ps < 4; ps++)
    begin
      ahb(1'b1, HOST_DIRECT_OFS, {29'h1, 2'(ps)} & 32'h7, rd);
      repeat (10) @(posedge hclk);
      chk("link byte", {29'h1, 2'(ps)} & 32'h7, {24'h0, last_wbyte});
      chk("manual select", 32'(ps), {30'h0, active_phase_select});
    end
    // Manual 00 must survive a pass that writes nothing
    ahb(1'b1, HOST_DIRECT_OFS, 32'h4, rd);
    run_align(32'h1f);
    chk("select persists", 32'h0, {30'h0, active_phase_select});
    // Manual off hands control back to the automatic choice
    ahb(1'b1, HOST_DIRECT_OFS, 32'h3, rd);
    repeat (10) @(posedge hclk);
    chk("auto restored", {30'h0, PS_DEFAULT[idx / DELAY_BINS]}, {30'h0, active_phase_select});
    // Zero reference: late exactly when the bin is late
    run_align(32'h0);
    chk("late flag", {31'h0, (idx % DELAY_BINS) >= LATE_BIN_MIN}, {31'h0, rd[2]});
    if ((idx % DELAY_BINS) >= LATE_BIN_MIN)
    begin
      repeat (10) @(posedge hclk);
      chk("corrected select", {30'h0, PS_DEFAULT[(idx / DELAY_BINS + 1) % PHASE_GROUPS]}, {30'h0, rd[17:16]});
      chk("device select", {30'h0, rd[17:16]}, {30'h0, active_phase_select});
      chk("manual byte", {30'h1, PS_DEFAULT[(idx / DELAY_BINS + 1) % PHASE_GROUPS]}, {24'h0, last_wbyte});
    end
    // Monitoring repeats the readout until switched off
    snap = n_reads;
    ahb(1'b1, HOST_CTRL_OFS, 32'h3, rd);
    repeat (300) @(posedge hclk);
    chk("monitor reads", 32'h1, {31'h0, n_reads - snap >= 5});
    ahb(1'b1, HOST_CTRL_OFS, 32'h0, rd);
    repeat (50) @(posedge hclk);
    snap = n_reads;
    repeat (100) @(posedge hclk);
    chk("monitor stopped", 32'(snap), 32'(n_reads));
    // Sample words reach the outputs as a pair
    for (int s = 0; s < 2; s++)
    begin
      sample_a_in <= 16'h1234 ^ 16'(s * 16'h0f0f);
      sample_b_in <= 16'habcd ^ 16'(s * 16'h0f0f);
      for (int k = 0; k < 300 && !(sample_update === 1'b1 && sample_a_out === (16'h1234 ^ 16'(s * 16'h0f0f))); k++)
        @(posedge hclk);
      chk("update pulse", 32'h1, {31'h0, sample_update});
      chk("port a out", {16'h0, 16'h1234 ^ 16'(s * 16'h0f0f)}, {16'h0, sample_a_out});
      chk("port b out", {16'h0, 16'habcd ^ 16'(s * 16'h0f0f)}, {16'h0, sample_b_out});
    end
    print_verdict();
  end
endmodule
